//--- core/cpv_pkg.sv
// Package of constants and types for the codec power, clock and volume bank
//
// How it works
// RL1: Input format code 000 is standard inter-IC sound, 001..100 are LSB-justified 16/18/20/24 bit, 101 is MSB-justified.
// RL2: Unused format codes 110 and 111 fall back to the default format.
// RL3: DAC power bit 15 powers the DAC when set, powers it down when clear, and resets to one.
// RL4: The DAC power bit drives the DAC power output directly, with no gating by mute or anything else.
// RL5: ADC bias power bit 8 at zero leaves both ADC channels unpowered.
// RL6: With bias on, bit 10 alone powers the left ADC and bit 9 alone powers the right ADC.
// RL7: Bit 7 enables the DAC clock when set and stops it when clear.
// RL8: With auto stop bit 6 set and the fractional PLL unlocked, the interpolator is muted and the DAC clock stops.
// RL9: Bit 2 runs the decimator and ADC clock when set, resets to one.
// RL10: Bit 0 runs the interpolator and filter-stream DAC clock when set, resets to one.
// RL11: The volume register holds left attenuation in bits 15..8 and right in bits 7..0.
// RL12: Each fine volume step adds 0.25 dB attenuation, code zero is 0 dB, down to -52 dB.
// RL13: Reserved bits read as zero and writes to them are ignored.
package cpv_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Indexes count words, so every index maps to byte address index * 4
  localparam int unsigned IDX_FORMAT   = 32'h0000_0002;
  localparam int unsigned IDX_PWR_CLK  = 32'h0000_0004;
  localparam int unsigned IDX_VOLUME   = 32'h0000_0010;
  localparam int unsigned IDX_STATUS   = 32'h0000_0020;
  localparam logic [11:0] ADDR_FORMAT  = 12'(IDX_FORMAT * 4);
  localparam logic [11:0] ADDR_PWR_CLK = 12'(IDX_PWR_CLK * 4);
  localparam logic [11:0] ADDR_VOLUME  = 12'(IDX_VOLUME * 4);
  localparam logic [11:0] ADDR_STATUS  = 12'(IDX_STATUS * 4);

  localparam int unsigned BIT_DAC_PWR  = 15;
  localparam int unsigned BIT_ADC_L    = 10;
  localparam int unsigned BIT_ADC_R    = 9;
  localparam int unsigned BIT_ADC_BIAS = 8;
  localparam int unsigned BIT_DAC_CLK  = 7;
  localparam int unsigned BIT_DAC_AUTO = 6;
  localparam int unsigned BIT_DEC_CLK  = 2;
  localparam int unsigned BIT_INT_CLK  = 0;

  localparam logic [15:0] PWR_CLK_MASK  = 16'h8_7c5;
  localparam logic [15:0] PWR_CLK_RESET = 16'h8_705;
  localparam logic [15:0] FORMAT_MASK   = 16'h0_007;
  localparam logic [15:0] FORMAT_RESET  = 16'h0_000;
  localparam logic [15:0] VOLUME_RESET  = 16'h0_000;

  localparam int unsigned FINE_LAST_CODE = 208;
  localparam int unsigned QDB_PER_STEP   = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_I2S    = 3'h0,
    FMT_LSB16  = 3'h1,
    FMT_LSB18  = 3'h2,
    FMT_LSB20  = 3'h3,
    FMT_LSB24  = 3'h4,
    FMT_MSB    = 3'h5
  } cpv_format_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cpv_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cpv_apb_rsp_t;

  typedef struct packed {
    logic dac_power_on;
    logic adc_left_power_on;
    logic adc_right_power_on;
    logic dac_clock_run;
    logic interp_mute;
    logic decimator_clock_run;
    logic interp_clock_run;
  } cpv_ctrl_t;

  typedef struct packed {
    cpv_format_t format;
    logic [8:0]  left_qdb;
    logic [8:0]  right_qdb;
    logic        left_mute;
    logic        right_mute;
  } cpv_audio_t;

endpackage : cpv_pkg

//--- core/cpv_atten.sv
// Attenuation code decoder for one master volume channel
`timescale 1ns/1ps
module cpv_atten (
  input  wire logic [7:0] i_code,
  output logic      [8:0] o_qdb,
  output logic            o_fine
);
  import cpv_pkg::*;

  // --------------------------------------------------------------
  // Fine range decode
  // --------------------------------------------------------------
  // RL12: quarter dB steps
  always_comb begin
    o_fine = ({1'b0, i_code} <= 9'(FINE_LAST_CODE));
    o_qdb  = o_fine ? 9'(i_code) * 9'(QDB_PER_STEP) : 9'(FINE_LAST_CODE);
  end

endmodule : cpv_atten

//--- core/cpv_ctrl_decode.sv
// Decode of the power and clock register into control outputs
`timescale 1ns/1ps
module cpv_ctrl_decode (
  input  wire logic [15:0]       i_pwr_clk,
  input  wire logic              i_pll_locked,
  output cpv_pkg::cpv_ctrl_t     o_ctrl
);
  import cpv_pkg::*;

  logic auto_stop;

  always_comb begin
    // RL8: stop on unlock
    auto_stop = i_pwr_clk[BIT_DAC_AUTO] & ~i_pll_locked;
    // RL3: DAC power bit
    // RL4: direct, ungated
    o_ctrl.dac_power_on       = i_pwr_clk[BIT_DAC_PWR];
    // RL5: bias gates both
    // RL6: independent channels
    o_ctrl.adc_left_power_on  = i_pwr_clk[BIT_ADC_BIAS] & i_pwr_clk[BIT_ADC_L];
    o_ctrl.adc_right_power_on = i_pwr_clk[BIT_ADC_BIAS] & i_pwr_clk[BIT_ADC_R];
    // RL7: set enables clock
    o_ctrl.dac_clock_run      = i_pwr_clk[BIT_DAC_CLK] & ~auto_stop;
    o_ctrl.interp_mute        = auto_stop;
    // RL9: decimator clock
    o_ctrl.decimator_clock_run = i_pwr_clk[BIT_DEC_CLK];
    // RL10: interpolator clock
    o_ctrl.interp_clock_run   = i_pwr_clk[BIT_INT_CLK];
  end

endmodule : cpv_ctrl_decode

//--- core/cpv_regs.sv
// APB register bank for codec format, power, clock and master volume
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module cpv_regs (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire cpv_pkg::cpv_apb_req_t i_apb,
  input  wire logic                  i_pll_locked,
  output cpv_pkg::cpv_apb_rsp_t      o_apb,
  output cpv_pkg::cpv_ctrl_t         o_ctrl,
  output cpv_pkg::cpv_audio_t        o_audio
);
  import cpv_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic [15:0] format;
    logic [15:0] pwr_clk;
    logic [15:0] volume;
    logic [31:0] rdata;
    cpv_ctrl_t   ctrl;
    cpv_audio_t  audio;
  } cpv_state_t;

  cpv_state_t  state_r;
  cpv_state_t  state_nxt;
  cpv_ctrl_t   ctrl_c;
  logic [8:0]  left_qdb;
  logic [8:0]  right_qdb;
  logic        left_fine;
  logic        right_fine;
  logic        access;
  logic        mapped;
  cpv_format_t fmt_c;

  cpv_ctrl_decode u_decode (
    .i_pwr_clk    (state_r.pwr_clk),
    .i_pll_locked (i_pll_locked),
    .o_ctrl       (ctrl_c)
  );

  // RL11: left in upper byte
  cpv_atten u_left (
    .i_code (state_r.volume[15:8]),
    .o_qdb  (left_qdb),
    .o_fine (left_fine)
  );

  // RL11: right in lower byte
  cpv_atten u_right (
    .i_code (state_r.volume[7:0]),
    .o_qdb  (right_qdb),
    .o_fine (right_fine)
  );

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    access    = i_apb.psel & i_apb.penable;
    mapped    = (i_apb.paddr == ADDR_FORMAT)  ||
                (i_apb.paddr == ADDR_PWR_CLK) ||
                (i_apb.paddr == ADDR_VOLUME)  ||
                (i_apb.paddr == ADDR_STATUS);
    if (access && i_apb.pwrite) begin
      // RL13: reserved bits dropped
      case (i_apb.paddr)
        ADDR_FORMAT:  state_nxt.format  = i_apb.pwdata[15:0] & FORMAT_MASK;
        ADDR_PWR_CLK: state_nxt.pwr_clk = i_apb.pwdata[15:0] & PWR_CLK_MASK;
        ADDR_VOLUME:  state_nxt.volume  = i_apb.pwdata[15:0];
        default:      state_nxt.rdata   = state_r.rdata;
      endcase
    end
    // Setup-phase read capture keeps prdata flopped for the access edge
    if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
      case (i_apb.paddr)
        ADDR_FORMAT:  state_nxt.rdata = {16'h0_000, state_r.format};
        ADDR_PWR_CLK: state_nxt.rdata = {16'h0_000, state_r.pwr_clk};
        ADDR_VOLUME:  state_nxt.rdata = {16'h0_000, state_r.volume};
        ADDR_STATUS:  state_nxt.rdata = {25'h000_0000, state_r.ctrl};
        default:      state_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // RL1: format select
    case (state_r.format[2:0])
      3'h0: fmt_c = FMT_I2S;
      3'h1: fmt_c = FMT_LSB16;
      3'h2: fmt_c = FMT_LSB18;
      3'h3: fmt_c = FMT_LSB20;
      3'h4: fmt_c = FMT_LSB24;
      3'h5: fmt_c = FMT_MSB;
      // RL2: unused codes default
      default: fmt_c = FMT_I2S;
    endcase
    state_nxt.ctrl             = ctrl_c;
    state_nxt.audio.format     = fmt_c;
    state_nxt.audio.left_qdb   = left_qdb;
    state_nxt.audio.right_qdb  = right_qdb;
    // Codes past the fine range treated as full mute here
    state_nxt.audio.left_mute  = ~left_fine | ctrl_c.interp_mute;
    state_nxt.audio.right_mute = ~right_fine | ctrl_c.interp_mute;
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r.format  <= FORMAT_RESET;
      state_r.pwr_clk <= PWR_CLK_RESET;
      state_r.volume  <= VOLUME_RESET;
      state_r.rdata   <= 32'h0000_0000;
      state_r.ctrl    <= '0;
      state_r.audio   <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------
  always_comb begin
    o_apb.pready  = 1'b1;
    o_apb.pslverr = i_apb.psel & i_apb.penable & ~mapped;
    o_apb.prdata  = state_r.rdata;
  end

  assign o_ctrl  = state_r.ctrl;
  assign o_audio = state_r.audio;

endmodule : cpv_regs

//--- testbench/cpv_host.sv
// Host model issuing APB transfers to the bank
`timescale 1ns/1ps
module cpv_host (
  input  wire cpv_pkg::cpv_apb_rsp_t i_apb,
  input  wire logic                  i_clk,
  output cpv_pkg::cpv_apb_req_t      o_apb
);
  import cpv_pkg::*;
  initial o_apb = '0;
  // Request held until ready seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge i_clk);
    o_apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    o_apb.penable <= 1'b1;
    @(posedge i_clk);
    while (i_apb.pready !== 1'b1) @(posedge i_clk);
    q = i_apb.prdata;
    e = i_apb.pslverr;
    o_apb <= '0;
  endtask : xfer
endmodule : cpv_host

//--- testbench/cpv_regs_checker.sv
// Port checker for the codec control register bank
`timescale 1ns/1ps
module cpv_regs_checker
  import cpv_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_reset_n,
  input wire cpv_pkg::cpv_apb_req_t i_apb,
  input wire logic                  i_pll_locked,
  input wire cpv_pkg::cpv_apb_rsp_t o_apb,
  input wire cpv_pkg::cpv_ctrl_t    o_ctrl,
  input wire cpv_pkg::cpv_audio_t   o_audio
);
  logic        wr, wr_pc, wr_vol, wr_fmt;
  logic [15:0] wd;
  assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign wr_pc = wr & (i_apb.paddr == ADDR_PWR_CLK);
  assign wr_vol = wr & (i_apb.paddr == ADDR_VOLUME);
  assign wr_fmt = wr & (i_apb.paddr == ADDR_FORMAT);
  assign wd = i_apb.pwdata[15:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_dac_pwr;
    wr_pc |-> ##2 o_ctrl.dac_power_on == $past(wd[15], 2);
  endproperty
  a_dac_pwr: assert property (p_dac_pwr) else $error("dac power");
  property p_adc_l;
    wr_pc |-> ##2 o_ctrl.adc_left_power_on == $past(wd[10] & wd[8], 2);
  endproperty
  a_adc_l: assert property (p_adc_l) else $error("adc left");
  property p_adc_r;
    wr_pc |-> ##2 o_ctrl.adc_right_power_on == $past(wd[9] & wd[8], 2);
  endproperty
  a_adc_r: assert property (p_adc_r) else $error("adc right");
  property p_dac_clk;
    wr_pc |-> ##2 o_ctrl.dac_clock_run ==
      ($past(wd[7], 2) & !($past(wd[6], 2) & !$past(i_pll_locked)));
  endproperty
  a_dac_clk: assert property (p_dac_clk) else $error("dac clock");
  property p_mute;
    wr_pc |-> ##2 o_ctrl.interp_mute == ($past(wd[6], 2) & !$past(i_pll_locked));
  endproperty
  a_mute: assert property (p_mute) else $error("auto mute");
  property p_dec;
    wr_pc |-> ##2 o_ctrl.decimator_clock_run == $past(wd[2], 2);
  endproperty
  a_dec: assert property (p_dec) else $error("decimator clock");
  property p_int;
    wr_pc |-> ##2 o_ctrl.interp_clock_run == $past(wd[0], 2);
  endproperty
  a_int: assert property (p_int) else $error("interp clock");
  property p_vol;
    wr_vol && wd[15:8] <= 8'd208 |-> ##2 o_audio.left_qdb == 9'($past(wd[15:8], 2));
  endproperty
  a_vol: assert property (p_vol) else $error("left volume");
  property p_fmt;
    wr_fmt && wd[2:0] > 3'd5 |-> ##2 o_audio.format == FMT_I2S;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format fallback");
endmodule : cpv_regs_checker
bind cpv_regs cpv_regs_checker i_cpv_regs_checker (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_apb(i_apb), .i_pll_locked(i_pll_locked),
  .o_apb(o_apb), .o_ctrl(o_ctrl), .o_audio(o_audio));

//--- testbench/tb_cpv_regs.sv
// Self-checking bench for the codec control register bank
`timescale 1ns/1ps
module tb_cpv_regs;
  import cpv_pkg::*;
  logic         i_clk = 0, i_reset_n = 0, pll = 1, e;
  cpv_apb_req_t req;
  cpv_apb_rsp_t rsp;
  cpv_ctrl_t    ctrl;
  cpv_audio_t   aud;
  int           errors = 0, checks_done = 0, pc = 'h8705, vol = 0, fmt = 0;
  logic [31:0]  d, q;
  logic [11:0]  a;
  always #2.5 i_clk = ~i_clk;
  cpv_regs i_cpv_regs (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(req),
    .i_pll_locked(pll), .o_apb(rsp), .o_ctrl(ctrl), .o_audio(aud));
  cpv_host i_cpv_host (.i_apb(rsp), .i_clk(i_clk), .o_apb(req));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  function automatic logic [6:0] ectl(int p, logic k);
    logic off;
    off = p[6] & !k;
    return {p[15], p[10] & p[8], p[9] & p[8], p[7] & !off, off, p[2], p[0]};
  endfunction : ectl
  function automatic logic [22:0] eaud(int f, int v, logic off);
    int l, r;
    l = v >> 8;
    r = v & 255;
    return {3'(f > 5 ? 0 : f), 9'(l > 208 ? 208 : l), 9'(r > 208 ? 208 : r),
            l > 208 || off, r > 208 || off};
  endfunction : eaud
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Whole run is about 1170 cycles
  initial begin
    #50us;
    errors++;
    end_sim();
  end
  initial begin
    q = $urandom(15509);
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1;
    repeat (2) @(posedge i_clk);
    #1 chk("reset ctrl", ctrl, ectl(pc, 1));
    i_cpv_host.xfer(1'b0, ADDR_PWR_CLK, '0, q, e);
    chk("reset pwr", q, pc);
    for (int i = 0; i < 96; i++) begin
      d = $urandom;
      case (i % 4)
        0: d[2:0] = 3'(i / 4);
        2: d[7:0] = 8'(200 + i % 16);
        default: ;
      endcase
      a = i % 4 == 0 ? ADDR_FORMAT : i % 4 == 1 ? ADDR_PWR_CLK :
          i % 4 == 2 ? ADDR_VOLUME : 12'h0_00c;
      @(posedge i_clk);
      pll <= 1'($urandom);
      i_cpv_host.xfer(1'b1, a, d, q, e);
      chk("slverr", e, a == 12'h0_00c);
      if (a == ADDR_FORMAT) fmt = d & 7;
      if (a == ADDR_PWR_CLK) pc = d & 'h87c5;
      if (a == ADDR_VOLUME) vol = d & 'hffff;
      repeat (2) @(posedge i_clk);
      #1 chk("ctrl", ctrl, ectl(pc, pll));
      chk("audio", aud, eaud(fmt, vol, pc[6] & !pll));
      i_cpv_host.xfer(1'b0, a, '0, q, e);
      chk("rdata", q, a == ADDR_FORMAT ? fmt : a == ADDR_PWR_CLK ? pc :
          a == ADDR_VOLUME ? vol : 0);
      i_cpv_host.xfer(1'b0, ADDR_STATUS, '0, q, e);
      chk("status", q, ectl(pc, pll));
    end
    end_sim();
  end
endmodule : tb_cpv_regs
